// file: design/status_pkg.sv
// Shared constants and types for the instrument status register groups
package status_pkg;
  // Register word width of every group
  localparam int WORD_W = 16;
  // Reset value of every stored group register
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Power group: three uncalibrated conditions in bits 2..0
  localparam logic [15:0] POWER_COND_MASK = 16'h0007;
  localparam logic [15:0] POWER_EVENT_MASK = 16'h0007;
  // Questionable group bit positions
  localparam int QUES_INDETERMINATE_BIT = 13;
  localparam int QUES_CALIBRATION_BIT = 8;
  localparam int QUES_POWER_BIT = 3;
  localparam logic [15:0] QUES_COND_MASK = 16'h2108;
  localparam logic [15:0] QUES_EVENT_MASK = 16'h2108;
  // Serial receiver error group: bits 8..1 are events only, bit 0 unused
  localparam int SERIAL_FIRST_BIT = 1;
  localparam int SERIAL_UNITS = 8;
  localparam logic [15:0] SERIAL_COND_MASK = 16'h0000;
  localparam logic [15:0] SERIAL_EVENT_MASK = 16'h01fe;
  // Register selected by a status command
  typedef enum logic [4:0] {
    REG_COND = 5'b00001,
    REG_RISE = 5'b00010,
    REG_FALL = 5'b00100,
    REG_EVENT = 5'b01000,
    REG_ENABLE = 5'b10000
  } reg_sel_e;
  // Group selected by a status command
  typedef enum logic [2:0] {
    GRP_POWER = 3'b001,
    GRP_QUES = 3'b010,
    GRP_SERIAL = 3'b100
  } group_sel_e;
endpackage

// file: design/group_if.sv
// Carrier between the command decoder and one status register group
interface group_if;
  logic wr;
  logic rd;
  status_pkg::reg_sel_e reg_sel;
  logic [15:0] wdata;
  logic clear;
  logic [15:0] cond;
  logic [15:0] set;
  logic [15:0] rdata;
  logic summary;
  modport group (input wr, rd, reg_sel, wdata, clear, cond, set, output rdata, summary);
  modport ctrl (output wr, rd, reg_sel, wdata, clear, cond, set, input rdata, summary);
endinterface

// file: design/status_group.sv
// One status register group: condition, transition filters, event and enable
module status_group #(
  parameter logic [15:0] COND_MASK = 16'h0000,
  parameter logic [15:0] EVENT_MASK = 16'h0000
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Command and source side
  group_if.group bus
);
  logic [15:0] cond_prev;
  logic [15:0] rise_filt;
  logic [15:0] fall_filt;
  logic [15:0] event_bits;
  logic [15:0] enable_bits;
  logic [15:0] next_event;
  wire [15:0] cond_now;
  wire [15:0] rising;
  wire [15:0] falling;
  wire [15:0] hits;
  wire event_clear;
  wire wr_rise;
  wire wr_fall;
  wire wr_enable;
  wire [15:0] wmasked;

  // Only implemented bits ever hold a one, so bit 15 and unused bits read zero
  assign cond_now = bus.cond & COND_MASK; // R4 R5
  assign wmasked = bus.wdata & EVENT_MASK; // R5
  // Edge detection against last cycle's condition, gated by the filters
  assign rising = cond_now & ~cond_prev & rise_filt; // R12
  assign falling = ~cond_now & cond_prev & fall_filt; // R12
  assign hits = (rising | falling | bus.set) & EVENT_MASK; // R12
  // A query of the event register and the clear-status command both empty it
  assign event_clear = bus.clear | (bus.rd && bus.reg_sel == status_pkg::REG_EVENT); // R1
  // A new hit in the clearing cycle survives the clear
  assign next_event = (event_bits & ~{16{event_clear}}) | hits; // R1 R12
  // Write decode
  assign wr_rise = bus.wr && bus.reg_sel == status_pkg::REG_RISE; // R3
  assign wr_fall = bus.wr && bus.reg_sel == status_pkg::REG_FALL; // R3
  assign wr_enable = bus.wr && bus.reg_sel == status_pkg::REG_ENABLE; // R2
  // Read selection; condition reads do not disturb anything
  assign bus.rdata = (bus.reg_sel == status_pkg::REG_COND) ? cond_now : // R4
                     (bus.reg_sel == status_pkg::REG_RISE) ? rise_filt : // R3
                     (bus.reg_sel == status_pkg::REG_FALL) ? fall_filt : // R3
                     (bus.reg_sel == status_pkg::REG_EVENT) ? event_bits :
                     (bus.reg_sel == status_pkg::REG_ENABLE) ? enable_bits : 16'h0000; // R2
  // Summary is any enabled event
  assign bus.summary = |(event_bits & enable_bits); // R12

  // Condition history and event latch
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cond_prev <= status_pkg::REG_RESET;
      event_bits <= status_pkg::REG_RESET;
    end else begin
      cond_prev <= cond_now;
      event_bits <= next_event;
    end
  end

  // Filters and enable hold the last written integer; zero clears the enable
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rise_filt <= status_pkg::REG_RESET;
      fall_filt <= status_pkg::REG_RESET;
      enable_bits <= status_pkg::REG_RESET;
    end else begin
      if (wr_rise) rise_filt <= wmasked; // R3
      if (wr_fall) fall_filt <= wmasked; // R3
      if (wr_enable) enable_bits <= wmasked; // R2
    end
  end
endmodule

// file: design/status_register_groups.sv
// Top of the power, questionable and serial receiver error status groups
// Function
// R1: Event register clears on query and clear-status
// R2: Enable holds last written value, zero clears
// R3: Rising and falling filters writable and readable
// R4: Condition query returns present state, no clear
// R5: Bit 15 and unused bits read zero
// R6: Questionable bits 13, 8, 3 mapped
// R7: Questionable summary drives status byte bit three
// R8: Serial errors on bits 1-8, event only
// R9: Serial summary reaches status byte bit zero
// R10: Both upstream enables needed for serial report
// R11: Serial errors captured only in power-up or self-test
// R12: Filtered edges latch events; summary is enabled OR
module status_register_groups (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Status command port
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [2:0] cmd_group_in,
  input wire logic [4:0] cmd_reg_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic clear_status_in,
  // Monitored conditions
  input wire logic [2:0] power_uncal_in,
  input wire logic indeterminate_in,
  input wire logic calibration_summary_in,
  input wire logic [7:0] serial_error_in,
  input wire logic power_up_check_in,
  input wire logic self_test_active_in,
  // Enables held by the communicate and hardware 1 groups
  input wire logic comm_serial_enable_in,
  input wire logic hw1_comm_enable_in,
  // Query response
  output logic resp_valid_out,
  output logic [15:0] resp_data_out,
  // Summaries
  output logic power_summary_out,
  output logic questionable_summary_out,
  output logic serial_summary_out,
  output logic status_byte_serial_out
);
  // Place one level at a given bit of a status word
  function automatic logic [15:0] place_bit(input logic value, input int pos);
    logic [15:0] word;
    word = 16'h0000;
    word[pos] = value;
    return word;
  endfunction

  // Spread the unit error pulses onto their event bits, leaving bit 0 unused
  function automatic logic [15:0] place_units(input logic [7:0] units);
    logic [15:0] word;
    word = 16'h0000;
    for (int i = 0; i < status_pkg::SERIAL_UNITS; i++) begin
      word[i + status_pkg::SERIAL_FIRST_BIT] = units[i]; // R8
    end
    return word;
  endfunction

  // Exactly one bit set; zero and multi-bit codes count as no selection
  function automatic logic one_hot(input logic [4:0] code);
    logic seen;
    logic twice;
    seen = 1'b0;
    twice = 1'b0;
    for (int i = 0; i < 5; i++) begin
      twice = twice | (seen & code[i]);
      seen = seen | code[i];
    end
    return seen & ~twice;
  endfunction

  group_if power_bus();
  group_if ques_bus();
  group_if serial_bus();

  // Command decode nets
  wire cmd_read;
  wire cmd_wr;
  wire group_ok;
  wire reg_ok;
  wire sel_power;
  wire sel_ques;
  wire sel_serial;
  // Per-group strobes
  wire power_wr;
  wire power_rd;
  wire ques_wr;
  wire ques_rd;
  wire serial_wr;
  wire serial_rd;
  // Condition, capture and answer nets
  wire serial_capture;
  wire [7:0] serial_gated;
  wire [15:0] serial_set;
  wire [15:0] ques_cond;
  wire [15:0] selected_rdata;
  wire serial_upstream_ok;
  wire status_byte_serial;

  // Command decode; a group or register code that is not one-hot selects nothing
  assign cmd_read = cmd_valid_in & ~cmd_write_in;
  assign cmd_wr = cmd_valid_in & cmd_write_in;
  assign group_ok = one_hot({2'b00, cmd_group_in});
  assign reg_ok = one_hot(cmd_reg_in);
  assign sel_power = group_ok & (cmd_group_in == status_pkg::GRP_POWER);
  assign sel_ques = group_ok & (cmd_group_in == status_pkg::GRP_QUES);
  assign sel_serial = group_ok & (cmd_group_in == status_pkg::GRP_SERIAL);

  // Strobes need a legal register code, so a garbled command leaves every group untouched
  assign power_wr = cmd_wr & sel_power & reg_ok; // R2 R3
  assign power_rd = cmd_read & sel_power & reg_ok; // R1
  assign ques_wr = cmd_wr & sel_ques & reg_ok; // R2 R3
  assign ques_rd = cmd_read & sel_ques & reg_ok; // R1
  assign serial_wr = cmd_wr & sel_serial & reg_ok; // R2 R3
  assign serial_rd = cmd_read & sel_serial & reg_ok; // R1

  // Power group wiring
  assign power_bus.wr = power_wr;
  assign power_bus.rd = power_rd;
  assign power_bus.reg_sel = status_pkg::reg_sel_e'(cmd_reg_in);
  assign power_bus.wdata = cmd_data_in;
  assign power_bus.clear = clear_status_in; // R1
  assign power_bus.cond = {13'h0, power_uncal_in};
  assign power_bus.set = 16'h0000;

  // Questionable group: power summary uses the registered copy, one cycle late
  assign ques_cond = place_bit(indeterminate_in, status_pkg::QUES_INDETERMINATE_BIT) | // R6
                     place_bit(calibration_summary_in, status_pkg::QUES_CALIBRATION_BIT) | // R6
                     place_bit(power_summary_out, status_pkg::QUES_POWER_BIT); // R6
  assign ques_bus.wr = ques_wr;
  assign ques_bus.rd = ques_rd;
  assign ques_bus.reg_sel = status_pkg::reg_sel_e'(cmd_reg_in);
  assign ques_bus.wdata = cmd_data_in;
  assign ques_bus.clear = clear_status_in; // R1
  assign ques_bus.cond = ques_cond;
  assign ques_bus.set = 16'h0000;

  // Serial errors are pulses with no condition; outside the check windows they are dropped
  assign serial_capture = power_up_check_in | self_test_active_in; // R11
  assign serial_gated = serial_error_in & {status_pkg::SERIAL_UNITS{serial_capture}}; // R11
  assign serial_set = place_units(serial_gated); // R8
  assign serial_bus.wr = serial_wr;
  assign serial_bus.rd = serial_rd;
  assign serial_bus.reg_sel = status_pkg::reg_sel_e'(cmd_reg_in);
  assign serial_bus.wdata = cmd_data_in;
  assign serial_bus.clear = clear_status_in; // R1
  assign serial_bus.cond = 16'h0000; // R8
  assign serial_bus.set = serial_set;

  // Response mux
  assign selected_rdata = sel_power ? power_bus.rdata :
                          sel_ques ? ques_bus.rdata :
                          sel_serial ? serial_bus.rdata : 16'h0000;
  // Serial summary passes the communicate and hardware 1 enables on its way up
  assign serial_upstream_ok = comm_serial_enable_in & hw1_comm_enable_in; // R10
  assign status_byte_serial = serial_bus.summary & serial_upstream_ok; // R9 R10

  // Power group instance
  status_group #(
    .COND_MASK(status_pkg::POWER_COND_MASK),
    .EVENT_MASK(status_pkg::POWER_EVENT_MASK)
  ) power_group (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .bus(power_bus.group)
  );

  // Questionable group instance
  status_group #(
    .COND_MASK(status_pkg::QUES_COND_MASK),
    .EVENT_MASK(status_pkg::QUES_EVENT_MASK)
  ) ques_group (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .bus(ques_bus.group)
  );

  // Serial receiver error group instance
  status_group #(
    .COND_MASK(status_pkg::SERIAL_COND_MASK),
    .EVENT_MASK(status_pkg::SERIAL_EVENT_MASK)
  ) serial_group (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .bus(serial_bus.group)
  );

  // Query answer one cycle after the command; event value is the pre-clear one
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      resp_valid_out <= 1'b0;
      resp_data_out <= 16'h0000;
    end else begin
      resp_valid_out <= cmd_read;
      if (cmd_read) resp_data_out <= selected_rdata; // R4 R5
    end
  end

  // Power and questionable summaries; registered so every output comes straight from a flop
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      power_summary_out <= 1'b0;
      questionable_summary_out <= 1'b0;
    end else begin
      power_summary_out <= power_bus.summary; // R12
      questionable_summary_out <= ques_bus.summary; // R7
    end
  end

  // Serial summary and its status byte bit; both lag the event register by one cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      serial_summary_out <= 1'b0;
      status_byte_serial_out <= 1'b0;
    end else begin
      serial_summary_out <= serial_bus.summary; // R12
      status_byte_serial_out <= status_byte_serial; // R9 R10
    end
  end
endmodule

// file: test/status_register_groups_sva.sv
// Port assertions for the status register groups
module status_register_groups_sva (
  input logic clk_in,
  input logic rst_in,
  input logic cmd_valid_in,
  input logic cmd_write_in,
  input logic [2:0] cmd_group_in,
  input logic [4:0] cmd_reg_in,
  input logic [15:0] cmd_data_in,
  input logic power_up_check_in,
  input logic self_test_active_in,
  input logic comm_serial_enable_in,
  input logic hw1_comm_enable_in,
  input logic resp_valid_out,
  input logic [15:0] resp_data_out,
  input logic power_summary_out,
  input logic serial_summary_out,
  input logic status_byte_serial_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Command shapes
  sequence s_query; cmd_valid_in && !cmd_write_in; endsequence
  sequence s_write; cmd_valid_in && cmd_write_in; endsequence
  sequence s_zero; s_write ##0 cmd_group_in == 3'b001 && cmd_reg_in == 5'b10000 && cmd_data_in == 16'h0000;
  endsequence
  // Unimplemented bits of a group never show in an answer
  property p_mask(g, m);
    s_query ##0 cmd_group_in == g |=> (resp_data_out & ~m) == 16'h0000;
  endproperty
  AST_ANSWER: assert property (s_query |=> resp_valid_out) else $error("query not answered");
  AST_NO_ANSWER: assert property (s_write |=> !resp_valid_out) else $error("write answered");
  AST_ORIGIN: assert property (resp_valid_out |-> $past(cmd_valid_in && !cmd_write_in))
    else $error("answer without query");
  AST_POWER_BITS: assert property (p_mask(3'b001, 16'h0007)) else $error("power unused bit set");
  AST_QUES_BITS: assert property (p_mask(3'b010, 16'h2108)) else $error("ques unused bit set");
  AST_SERIAL_BITS: assert property (p_mask(3'b100, 16'h01fe)) else $error("serial unused bit set");
  AST_SB_GATE: assert property (!(comm_serial_enable_in && hw1_comm_enable_in) |=> !status_byte_serial_out)
    else $error("status byte bit without enables");
  AST_SB_SOURCE: assert property (status_byte_serial_out |-> serial_summary_out || $past(serial_summary_out))
    else $error("status byte bit without summary");
  AST_WINDOW: assert property ($rose(serial_summary_out) |->
    $past(power_up_check_in || self_test_active_in || (cmd_valid_in && cmd_write_in), 2))
    else $error("serial event outside window");
  AST_ENABLE_ZERO: assert property (s_zero |=> ##1 !power_summary_out) else $error("summary after zero enable");
endmodule
bind status_register_groups status_register_groups_sva u_sva (.clk_in, .rst_in, .cmd_valid_in, .cmd_write_in,
  .cmd_group_in, .cmd_reg_in, .cmd_data_in, .power_up_check_in, .self_test_active_in, .comm_serial_enable_in,
  .hw1_comm_enable_in, .resp_valid_out, .resp_data_out, .power_summary_out, .serial_summary_out,
  .status_byte_serial_out);

// file: test/status_ctrl_model.sv
// Remote controller model issuing one status command at a time
module status_ctrl_model (
  input wire logic clk_in,
  output logic cmd_valid_out,
  output logic cmd_write_out,
  output logic [2:0] cmd_group_out,
  output logic [4:0] cmd_reg_out,
  output logic [15:0] cmd_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cmd_valid_out, cmd_write_out, cmd_group_out, cmd_reg_out, cmd_data_out} = '0;
  // Idle cycle after each command keeps valid a clean one-cycle pulse
  task automatic cmd(input logic w, input logic [2:0] g, input logic [4:0] r, input logic [15:0] d);
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_write_out <= w;
    cmd_group_out <= g;
    cmd_reg_out <= r;
    cmd_data_out <= d;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_data_out <= ~d; // No stale word left on the idle bus
  endtask
endmodule

// file: test/status_register_groups_tb.sv
// Self-checking bench for the status register groups
module status_register_groups_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rst_in, cmd_valid_in, cmd_write_in, clear_status_in, indeterminate_in, calibration_summary_in;
  logic power_up_check_in, self_test_active_in, comm_serial_enable_in, hw1_comm_enable_in, resp_valid_out;
  logic power_summary_out, questionable_summary_out, serial_summary_out, status_byte_serial_out;
  logic [2:0] cmd_group_in, power_uncal_in;
  logic [4:0] cmd_reg_in;
  logic [7:0] serial_error_in;
  logic [15:0] cmd_data_in, resp_data_out, d;
  logic [15:0] exp_q[$];
  logic [15:0] masks[3] = '{16'h0007, 16'h2108, 16'h01fe};
  logic [4:0] regs[3] = '{5'b00010, 5'b00100, 5'b10000};
  integer seed = 32'h35e5;
  int fails = 0;
  int tests_run = 0;
  status_ctrl_model u_ctrl (.clk_in, .cmd_valid_out(cmd_valid_in), .cmd_write_out(cmd_write_in),
    .cmd_group_out(cmd_group_in), .cmd_reg_out(cmd_reg_in), .cmd_data_out(cmd_data_in));
  status_register_groups u_status_register_groups (.*);
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // Answers return in order, so the oldest note belongs to this one
  always @(posedge clk_in) if (resp_valid_out === 1'b1) chk(resp_data_out, exp_q.pop_front());
  // Run needs well under 1000 cycles
  initial begin
    #100us;
    fails++;
    print_verdict;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] g, input logic [4:0] r, input logic [15:0] v);
    u_ctrl.cmd(1'b1, g, r, v);
  endtask
  task automatic rd(input logic [2:0] g, input logic [4:0] r, input logic [15:0] e);
    exp_q.push_back(e);
    u_ctrl.cmd(1'b0, g, r, 16'h0000);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic pulse(input logic [7:0] v);
    serial_error_in <= v;
    tick(1);
    serial_error_in <= 8'h00;
  endtask
  task automatic print_verdict;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    rst_in = 1'b1;
    {clear_status_in, power_uncal_in, indeterminate_in, calibration_summary_in, serial_error_in} = '0;
    {power_up_check_in, self_test_active_in, comm_serial_enable_in, hw1_comm_enable_in} = '0;
    tick(20);
    rst_in <= 1'b0;
    // Filters and enables keep only implemented bits
    for (int g = 0; g < 3; g++) for (int r = 0; r < 3; r++) begin
      d = 16'($random(seed));
      wr(3'(1 << g), regs[r], d);
      rd(3'(1 << g), regs[r], d & masks[g]);
    end
    wr(3'b001, 5'b10000, 16'h0000);
    rd(3'b001, 5'b10000, 16'h0000);
    // Power edges through both filters, feeding questionable bit 3
    wr(3'b001, 5'b00010, 16'hffff);
    wr(3'b001, 5'b00100, 16'hffff);
    wr(3'b001, 5'b10000, 16'h0007);
    wr(3'b010, 5'b00010, 16'h2108);
    wr(3'b010, 5'b10000, 16'h2108);
    power_uncal_in <= 3'b101;
    indeterminate_in <= 1'b1;
    calibration_summary_in <= 1'b1;
    tick(4);
    chk(16'(questionable_summary_out), 16'h0001);
    chk(16'(power_summary_out), 16'h0001);
    rd(3'b010, 5'b00001, 16'h2108);
    rd(3'b001, 5'b00001, 16'h0005);
    rd(3'b001, 5'b01000, 16'h0005);
    rd(3'b001, 5'b01000, 16'h0000);
    rd(3'b001, 5'b00001, 16'h0005);
    power_uncal_in <= 3'b000;
    tick(3);
    rd(3'b001, 5'b01000, 16'h0005);
    power_uncal_in <= 3'b010;
    tick(3);
    clear_status_in <= 1'b1;
    tick(1);
    clear_status_in <= 1'b0;
    rd(3'b001, 5'b01000, 16'h0000);
    // A rising edge that the filter does not permit leaves the event register empty
    wr(3'b001, 5'b00010, 16'h0000);
    power_uncal_in <= 3'b111;
    tick(3);
    rd(3'b001, 5'b01000, 16'h0000);
    // Serial errors count only inside a capture window
    wr(3'b100, 5'b10000, 16'h01fe);
    comm_serial_enable_in <= 1'b1;
    d = 16'($random(seed));
    pulse(d[7:0] | 8'h01);
    rd(3'b100, 5'b01000, 16'h0000);
    chk(16'(serial_summary_out), 16'h0000);
    self_test_active_in <= 1'b1;
    pulse(8'h81);
    tick(3);
    chk(16'(status_byte_serial_out), 16'h0000);
    hw1_comm_enable_in <= 1'b1;
    tick(3);
    chk(16'(status_byte_serial_out), 16'h0001);
    chk(16'(serial_summary_out), 16'h0001);
    rd(3'b100, 5'b01000, 16'h0102);
    self_test_active_in <= 1'b0;
    power_up_check_in <= 1'b1;
    pulse(d[7:0]);
    rd(3'b100, 5'b01000, {7'h00, d[7:0], 1'b0});
    rd(3'b100, 5'b00001, 16'h0000);
    tick(4);
    print_verdict;
  end
endmodule
